/* sscsm_defs.vh */
// Purpose: Shared constants of the command service mapper: frame codes, field positions,
//          register offsets and reset values.
// Assumes: Included by its bare name from every design file.
// Notes:   Definitions only.
`ifndef SSCSM_DEFS_VH
`define SSCSM_DEFS_VH

// Frame type codes in header bits 31:24.
`define SSCSM_IU_DATA 8'h01
`define SSCSM_IU_COMMAND 8'h06
`define SSCSM_IU_RESPONSE 8'h07

// Header field positions.
`define SSCSM_HDR_TYPE 31:24
`define SSCSM_HDR_LUN 23:16
`define SSCSM_HDR_TAG 15:0

// Response and command word 1 field positions.
`define SSCSM_RSP_INFOV_BIT 8
`define SSCSM_RSP_STATUS 7:0
`define SSCSM_ATTR_FIELD 2:0

// Status codes that mark a linked command.
`define SSCSM_ST_INTERMEDIATE 8'h10
`define SSCSM_ST_INTER_COND_MET 8'h14

// Service response codes.
`define SSCSM_SVC_TASK_COMPLETE 2'h0
`define SSCSM_SVC_LINKED_COMPLETE 2'h1
`define SSCSM_SVC_FAILURE 2'h2

// Last word index of fixed-length frames.
`define SSCSM_CMD_LAST_IDX 3'h5
`define SSCSM_RSP_LAST_IDX 3'h2

// Register byte offsets.
`define SSCSM_REG_CTRL 8'h00
`define SSCSM_REG_NEXUS 8'h04
`define SSCSM_REG_ATTR 8'h08
`define SSCSM_REG_CDB0 8'h0C
`define SSCSM_REG_CDB1 8'h10
`define SSCSM_REG_CDB2 8'h14
`define SSCSM_REG_CDB3 8'h18
`define SSCSM_REG_DIN_SIZE 8'h1C
`define SSCSM_REG_DOUT_SIZE 8'h20
`define SSCSM_REG_RSP_STATUS 8'h24
`define SSCSM_REG_RSP_SENSE 8'h28
`define SSCSM_REG_RD_BYTES 8'h2C
`define SSCSM_REG_INT_STATUS 8'h30
`define SSCSM_REG_INT_MASK 8'h34
`define SSCSM_REG_DATA_IUS 8'h38
`define SSCSM_BUF_WINDOW_BIT 7

// Control bits.
`define SSCSM_CTRL_SEND_BIT 0

// Interrupt bits.
`define SSCSM_INT_CMD_DONE 0
`define SSCSM_INT_DATA_IU 1
`define SSCSM_INT_CMD_RCVD 2
`define SSCSM_INT_OVERFLOW 3
`define SSCSM_INT_W 4

// Read buffer geometry.
`define SSCSM_BUF_DEPTH 32
`define SSCSM_BUF_AW 5
`define SSCSM_BUF_BYTES 32'h00000080

// Reset values.
`define SSCSM_RST_SIZE 32'h00000000
`define SSCSM_RST_MASK 4'h0

`endif

/* sscsm_svc_decode.v */
// Purpose: Decodes the service response from a completion's status, info-valid bit and NAK.
// Assumes: Pure combinational; the caller registers the result.
// Notes:   A NAK or a set info-valid bit overrides whatever the status says.
`timescale 1ns/1ns
`include "sscsm_defs.vh"
module sscsm_svc_decode (
    input wire [7:0] status_in,
    input wire info_valid_in,
    input wire nak_in,
    output reg [1:0] svc_out
);
    always @* begin
        if (nak_in || info_valid_in) begin
            svc_out = `SSCSM_SVC_FAILURE;
        end else if (status_in == `SSCSM_ST_INTERMEDIATE || status_in == `SSCSM_ST_INTER_COND_MET) begin
            svc_out = `SSCSM_SVC_LINKED_COMPLETE;
        end else begin
            svc_out = `SSCSM_SVC_TASK_COMPLETE;
        end
    end
endmodule

/* sscsm_rdbuf.v */
// Purpose: Read-data destination buffer held inside the initiator port.
// Assumes: One write port and one read port on the same clock.
// Notes:   Read data come out of a register one cycle after the read enable.
`timescale 1ns/1ns
`include "sscsm_defs.vh"
module sscsm_rdbuf (
    input wire clk_sys_in,
    input wire ce_in,
    input wire we_in,
    input wire [`SSCSM_BUF_AW-1:0] waddr_in,
    input wire [31:0] wdata_in,
    input wire re_in,
    input wire [`SSCSM_BUF_AW-1:0] raddr_in,
    output reg [31:0] rdata_out
);
    reg [31:0] mem_r [0:`SSCSM_BUF_DEPTH-1];

    always @(posedge clk_sys_in) begin
        if (ce_in) begin
            if (we_in) begin
                mem_r[waddr_in] <= wdata_in;
            end
            if (re_in) begin
                rdata_out <= mem_r[raddr_in];
            end
        end
    end
endmodule

/* sscsm_mapper.v */
// Purpose: Maps command, completion and read-data services onto serial frames, for both the
//          initiator port (register driven) and the target device server (port driven).
// Assumes: Frames are 32-bit word streams with start and end marks; word 0 is the header.
//          Frames of a single word are ignored.
// Notes:   Only one outstanding command per initiator; write data and task management absent.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "sscsm_defs.vh"
module sscsm_mapper (
    input wire clk_sys_in,
    input wire reset_in,
    input wire ce_in,
    input wire [7:0] addr_in,
    input wire [31:0] wr_data_in,
    input wire wr_en_in,
    input wire rd_en_in,
    output wire [31:0] rd_data_out,
    output reg irq_out,
    input wire conn_open_in,
    input wire [15:0] conn_it_in,
    output reg tx_valid_out,
    output reg [31:0] tx_data_out,
    output reg tx_sof_out,
    output reg tx_eof_out,
    input wire tx_ready_in,
    input wire rx_valid_in,
    input wire [31:0] rx_data_in,
    input wire rx_sof_in,
    input wire rx_eof_in,
    input wire rx_nak_in,
    output reg cmd_rcvd_out,
    output reg [15:0] tgt_it_out,
    output reg [7:0] tgt_lun_out,
    output reg [15:0] tgt_tag_out,
    output reg [2:0] tgt_attr_out,
    output reg [127:0] tgt_cdb_out,
    input wire rsp_req_in,
    input wire [7:0] rsp_lun_in,
    input wire [15:0] rsp_tag_in,
    input wire [7:0] rsp_status_in,
    input wire rsp_info_valid_in,
    input wire [31:0] rsp_sense_in,
    output reg rsp_busy_out,
    input wire din_valid_in,
    input wire [31:0] din_data_in,
    input wire din_last_in,
    input wire [7:0] din_lun_in,
    input wire [15:0] din_tag_in,
    output reg din_ready_out,
    output reg [31:0] tgt_din_bytes_out
);
    localparam T_IDLE = 2'h0;
    localparam T_CMD = 2'h1;
    localparam T_RSP = 2'h2;
    localparam T_DATA = 2'h3;

    reg [1:0] tx_state_r;
    reg [2:0] tx_idx_r;
    reg cmd_pend_r;
    reg cmd_wait_r;
    reg [7:0] cmd_lun_r;
    reg [15:0] cmd_tag_r;
    reg [15:0] cmd_it_r;
    reg [2:0] cmd_attr_r;
    reg [31:0] cmd_cdb_r [0:3];
    reg [31:0] din_size_r;
    reg [31:0] dout_size_r;
    reg [7:0] rsp_status_r;
    reg rsp_infov_r;
    reg [31:0] rsp_sense_r;
    reg [1:0] svc_r;
    reg [31:0] rd_bytes_r;
    reg [31:0] data_ius_r;
    reg [`SSCSM_INT_W-1:0] int_status_r;
    reg [`SSCSM_INT_W-1:0] int_status_nxt;
    reg [`SSCSM_INT_W-1:0] int_mask_r;
    reg [`SSCSM_INT_W-1:0] int_ev;
    reg [7:0] prsp_lun_r;
    reg [15:0] prsp_tag_r;
    reg [7:0] prsp_status_r;
    reg prsp_infov_r;
    reg [31:0] prsp_sense_r;
    reg [7:0] rx_type_r;
    reg [7:0] rx_lun_r;
    reg [15:0] rx_tag_r;
    reg [2:0] rx_idx_r;
    reg rx_act_r;
    reg [31:0] rd_q_r;
    reg rd_mem_sel_r;
    reg [31:0] reg_rd_val;

    wire tx_free = !tx_valid_out || tx_ready_in;
    wire rx_word = rx_valid_in && conn_open_in && !rx_sof_in && rx_act_r;
    // The pair, unit and tag must all match before a frame is taken as ours.
    wire rx_match = cmd_wait_r && (rx_lun_r == cmd_lun_r) && (rx_tag_r == cmd_tag_r)
        && (conn_it_in == cmd_it_r);
    wire rx_is_rsp = rx_word && rx_match && (rx_type_r == `SSCSM_IU_RESPONSE);
    wire rx_is_data = rx_word && rx_match && (rx_type_r == `SSCSM_IU_DATA);
    wire rx_is_cmd = rx_word && (rx_type_r == `SSCSM_IU_COMMAND);
    wire nak_now = rx_nak_in && cmd_wait_r && !cmd_pend_r;
    wire rsp_done = rx_is_rsp && rx_eof_in;
    wire [31:0] rd_bytes_inc = rd_bytes_r + 32'h00000004;
    wire data_fits = (rd_bytes_inc <= din_size_r) && (rd_bytes_r < `SSCSM_BUF_BYTES);
    wire buf_we = rx_is_data && rx_idx_r != 3'h0 && data_fits;
    wire wr_hit = wr_en_in && !addr_in[`SSCSM_BUF_WINDOW_BIT];
    wire [1:0] svc_dec;

    sscsm_svc_decode u_dec (
        .status_in(rsp_status_r),
        .info_valid_in(rsp_infov_r),
        .nak_in(nak_now),
        .svc_out(svc_dec)
    );

    wire [31:0] rd_mem_q;

    // The buffer stays inside the port; software reads it through the window.
    sscsm_rdbuf u_buf (
        .clk_sys_in(clk_sys_in),
        .ce_in(ce_in),
        .we_in(buf_we),
        .waddr_in(rd_bytes_r[`SSCSM_BUF_AW+1:2]),
        .wdata_in(rx_data_in),
        .re_in(rd_en_in && addr_in[`SSCSM_BUF_WINDOW_BIT]),
        .raddr_in(addr_in[`SSCSM_BUF_AW+1:2]),
        .rdata_out(rd_mem_q)
    );

    assign rd_data_out = rd_mem_sel_r ? rd_mem_q : rd_q_r;

    always @* begin
        int_ev = {`SSCSM_INT_W{1'b0}};
        int_ev[`SSCSM_INT_CMD_DONE] = rsp_done || nak_now;
        int_ev[`SSCSM_INT_DATA_IU] = rx_is_data && rx_eof_in;
        int_ev[`SSCSM_INT_CMD_RCVD] = rx_is_cmd && rx_eof_in;
        int_ev[`SSCSM_INT_OVERFLOW] = rx_is_data && !data_fits;
        // A new event wins over a clear in the same cycle.
        int_status_nxt = int_status_r | int_ev;
        if (wr_hit && addr_in == `SSCSM_REG_INT_STATUS) begin
            int_status_nxt = (int_status_r & ~wr_data_in[`SSCSM_INT_W-1:0]) | int_ev;
        end
    end

    always @* begin
        reg_rd_val = 32'h00000000;
        case (addr_in)
            `SSCSM_REG_CTRL: reg_rd_val = {31'h00000000, cmd_pend_r || cmd_wait_r};
            `SSCSM_REG_NEXUS: reg_rd_val = {8'h00, cmd_lun_r, cmd_tag_r};
            `SSCSM_REG_ATTR: reg_rd_val = {29'h00000000, cmd_attr_r};
            `SSCSM_REG_CDB0: reg_rd_val = cmd_cdb_r[0];
            `SSCSM_REG_CDB1: reg_rd_val = cmd_cdb_r[1];
            `SSCSM_REG_CDB2: reg_rd_val = cmd_cdb_r[2];
            `SSCSM_REG_CDB3: reg_rd_val = cmd_cdb_r[3];
            `SSCSM_REG_DIN_SIZE: reg_rd_val = din_size_r;
            `SSCSM_REG_DOUT_SIZE: reg_rd_val = dout_size_r;
            `SSCSM_REG_RSP_STATUS: reg_rd_val = {21'h000000, svc_r, rsp_infov_r, rsp_status_r};
            `SSCSM_REG_RSP_SENSE: reg_rd_val = rsp_sense_r;
            `SSCSM_REG_RD_BYTES: reg_rd_val = rd_bytes_r;
            `SSCSM_REG_INT_STATUS: reg_rd_val = {28'h0000000, int_status_r};
            `SSCSM_REG_INT_MASK: reg_rd_val = {28'h0000000, int_mask_r};
            `SSCSM_REG_DATA_IUS: reg_rd_val = data_ius_r;
            default: reg_rd_val = 32'h00000000;
        endcase
    end

    // Register file, initiator command state and interrupt logic.
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            cmd_lun_r <= 8'h00;
            cmd_tag_r <= 16'h0000;
            cmd_attr_r <= 3'h0;
            cmd_cdb_r[0] <= 32'h00000000;
            cmd_cdb_r[1] <= 32'h00000000;
            cmd_cdb_r[2] <= 32'h00000000;
            cmd_cdb_r[3] <= 32'h00000000;
            din_size_r <= `SSCSM_RST_SIZE;
            dout_size_r <= `SSCSM_RST_SIZE;
            int_status_r <= {`SSCSM_INT_W{1'b0}};
            int_mask_r <= `SSCSM_RST_MASK;
            irq_out <= 1'b0;
            rd_q_r <= 32'h00000000;
            rd_mem_sel_r <= 1'b0;
            rsp_status_r <= 8'h00;
            rsp_infov_r <= 1'b0;
            rsp_sense_r <= 32'h00000000;
            svc_r <= `SSCSM_SVC_TASK_COMPLETE;
            rd_bytes_r <= 32'h00000000;
            data_ius_r <= 32'h00000000;
            cmd_wait_r <= 1'b0;
        end else if (ce_in) begin
            int_status_r <= int_status_nxt;
            irq_out <= |(int_status_nxt & int_mask_r);
            rd_mem_sel_r <= rd_en_in && addr_in[`SSCSM_BUF_WINDOW_BIT];
            if (rd_en_in) begin
                rd_q_r <= reg_rd_val;
            end
            if (wr_hit) begin
                case (addr_in)
                    `SSCSM_REG_NEXUS: begin
                        cmd_lun_r <= wr_data_in[`SSCSM_HDR_LUN];
                        cmd_tag_r <= wr_data_in[`SSCSM_HDR_TAG];
                    end
                    `SSCSM_REG_ATTR: cmd_attr_r <= wr_data_in[`SSCSM_ATTR_FIELD];
                    `SSCSM_REG_CDB0: cmd_cdb_r[0] <= wr_data_in;
                    `SSCSM_REG_CDB1: cmd_cdb_r[1] <= wr_data_in;
                    `SSCSM_REG_CDB2: cmd_cdb_r[2] <= wr_data_in;
                    `SSCSM_REG_CDB3: cmd_cdb_r[3] <= wr_data_in;
                    `SSCSM_REG_DIN_SIZE: din_size_r <= wr_data_in;
                    `SSCSM_REG_DOUT_SIZE: dout_size_r <= wr_data_in;
                    `SSCSM_REG_INT_MASK: int_mask_r <= wr_data_in[`SSCSM_INT_W-1:0];
                    default: begin
                    end
                endcase
            end
            // A new command restarts the read-data accounting.
            if (wr_hit && addr_in == `SSCSM_REG_CTRL && wr_data_in[`SSCSM_CTRL_SEND_BIT]
                && !cmd_pend_r && !cmd_wait_r) begin
                rd_bytes_r <= 32'h00000000;
                data_ius_r <= 32'h00000000;
            end else if (buf_we) begin
                rd_bytes_r <= rd_bytes_inc;
            end
            if (rx_is_data && rx_eof_in) begin
                data_ius_r <= data_ius_r + 32'h00000001;
            end
            if (rx_is_rsp && rx_idx_r == 3'h1) begin
                rsp_status_r <= rx_data_in[`SSCSM_RSP_STATUS];
                rsp_infov_r <= rx_data_in[`SSCSM_RSP_INFOV_BIT];
            end
            if (rx_is_rsp && rx_idx_r == 3'h2) begin
                rsp_sense_r <= rx_data_in;
            end
            if (tx_state_r == T_CMD && tx_free && tx_idx_r == `SSCSM_CMD_LAST_IDX) begin
                cmd_wait_r <= 1'b1;
            end else if (rsp_done || nak_now) begin
                cmd_wait_r <= 1'b0;
                svc_r <= svc_dec;
            end
        end
    end

    // Frame transmitter shared by command, response and read-data frames.
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            tx_state_r <= T_IDLE;
            tx_idx_r <= 3'h0;
            tx_valid_out <= 1'b0;
            tx_data_out <= 32'h00000000;
            tx_sof_out <= 1'b0;
            tx_eof_out <= 1'b0;
            cmd_pend_r <= 1'b0;
            cmd_it_r <= 16'h0000;
            rsp_busy_out <= 1'b0;
            prsp_lun_r <= 8'h00;
            prsp_tag_r <= 16'h0000;
            prsp_status_r <= 8'h00;
            prsp_infov_r <= 1'b0;
            prsp_sense_r <= 32'h00000000;
            din_ready_out <= 1'b0;
            tgt_din_bytes_out <= 32'h00000000;
        end else if (ce_in) begin
            if (tx_valid_out && tx_ready_in) begin
                tx_valid_out <= 1'b0;
            end
            if (wr_hit && addr_in == `SSCSM_REG_CTRL && wr_data_in[`SSCSM_CTRL_SEND_BIT]
                && !cmd_pend_r && !cmd_wait_r) begin
                cmd_pend_r <= 1'b1;
            end
            if (rsp_req_in && !rsp_busy_out) begin
                rsp_busy_out <= 1'b1;
                prsp_lun_r <= rsp_lun_in;
                prsp_tag_r <= rsp_tag_in;
                prsp_status_r <= rsp_status_in;
                prsp_infov_r <= rsp_info_valid_in;
                prsp_sense_r <= rsp_sense_in;
            end
            case (tx_state_r)
                T_IDLE: begin
                    if (tx_free && conn_open_in) begin
                        if (cmd_pend_r) begin
                            tx_valid_out <= 1'b1;
                            tx_sof_out <= 1'b1;
                            tx_eof_out <= 1'b0;
                            tx_data_out <= {`SSCSM_IU_COMMAND, cmd_lun_r, cmd_tag_r};
                            cmd_it_r <= conn_it_in;
                            tx_idx_r <= 3'h1;
                            tx_state_r <= T_CMD;
                        end else if (rsp_busy_out) begin
                            tx_valid_out <= 1'b1;
                            tx_sof_out <= 1'b1;
                            tx_eof_out <= 1'b0;
                            tx_data_out <= {`SSCSM_IU_RESPONSE, prsp_lun_r, prsp_tag_r};
                            tx_idx_r <= 3'h1;
                            tx_state_r <= T_RSP;
                        end else if (din_valid_in) begin
                            tx_valid_out <= 1'b1;
                            tx_sof_out <= 1'b1;
                            tx_eof_out <= 1'b0;
                            tx_data_out <= {`SSCSM_IU_DATA, din_lun_in, din_tag_in};
                            tx_state_r <= T_DATA;
                        end
                    end
                end
                T_CMD: begin
                    if (tx_free) begin
                        tx_valid_out <= 1'b1;
                        tx_sof_out <= 1'b0;
                        tx_eof_out <= (tx_idx_r == `SSCSM_CMD_LAST_IDX);
                        if (tx_idx_r == 3'h1) begin
                            tx_data_out <= {29'h00000000, cmd_attr_r};
                        end else begin
                            tx_data_out <= cmd_cdb_r[tx_idx_r[1:0] - 2'h2];
                        end
                        tx_idx_r <= tx_idx_r + 3'h1;
                        if (tx_idx_r == `SSCSM_CMD_LAST_IDX) begin
                            cmd_pend_r <= 1'b0;
                            tx_state_r <= T_IDLE;
                        end
                    end
                end
                T_RSP: begin
                    if (tx_free) begin
                        tx_valid_out <= 1'b1;
                        tx_sof_out <= 1'b0;
                        tx_eof_out <= (tx_idx_r == `SSCSM_RSP_LAST_IDX);
                        if (tx_idx_r == 3'h1) begin
                            tx_data_out <= {23'h000000, prsp_infov_r, prsp_status_r};
                        end else begin
                            tx_data_out <= prsp_sense_r;
                        end
                        tx_idx_r <= tx_idx_r + 3'h1;
                        if (tx_idx_r == `SSCSM_RSP_LAST_IDX) begin
                            rsp_busy_out <= 1'b0;
                            tgt_din_bytes_out <= 32'h00000000;
                            tx_state_r <= T_IDLE;
                        end
                    end
                end
                T_DATA: begin
                    // Ready rises only once the previous word has left, so a taken word never overwrites.
                    if (din_ready_out && din_valid_in) begin
                        din_ready_out <= 1'b0;
                        tx_valid_out <= 1'b1;
                        tx_sof_out <= 1'b0;
                        tx_eof_out <= din_last_in;
                        tx_data_out <= din_data_in;
                        tgt_din_bytes_out <= tgt_din_bytes_out + 32'h00000004;
                        if (din_last_in) begin
                            tx_state_r <= T_IDLE;
                        end
                    end else if (!din_ready_out && tx_free) begin
                        din_ready_out <= 1'b1;
                    end
                end
                default: tx_state_r <= T_IDLE;
            endcase
        end
    end

    // Frame receiver: header capture and target command parsing.
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            rx_type_r <= 8'h00;
            rx_lun_r <= 8'h00;
            rx_tag_r <= 16'h0000;
            rx_idx_r <= 3'h0;
            rx_act_r <= 1'b0;
            cmd_rcvd_out <= 1'b0;
            tgt_it_out <= 16'h0000;
            tgt_lun_out <= 8'h00;
            tgt_tag_out <= 16'h0000;
            tgt_attr_out <= 3'h0;
            tgt_cdb_out <= 128'h0;
        end else if (ce_in) begin
            cmd_rcvd_out <= rx_is_cmd && rx_eof_in;
            if (rx_valid_in && conn_open_in && rx_sof_in) begin
                rx_type_r <= rx_data_in[`SSCSM_HDR_TYPE];
                rx_lun_r <= rx_data_in[`SSCSM_HDR_LUN];
                rx_tag_r <= rx_data_in[`SSCSM_HDR_TAG];
                rx_idx_r <= 3'h1;
                rx_act_r <= !rx_eof_in;
            end else if (rx_word) begin
                if (rx_idx_r != 3'h7) begin
                    rx_idx_r <= rx_idx_r + 3'h1;
                end
                if (rx_eof_in) begin
                    rx_act_r <= 1'b0;
                end
                if (rx_is_cmd) begin
                    if (rx_idx_r == 3'h1) begin
                        tgt_attr_out <= rx_data_in[`SSCSM_ATTR_FIELD];
                        tgt_it_out <= conn_it_in;
                        tgt_lun_out <= rx_lun_r;
                        tgt_tag_out <= rx_tag_r;
                    end
                    case (rx_idx_r)
                        3'h2: tgt_cdb_out[31:0] <= rx_data_in;
                        3'h3: tgt_cdb_out[63:32] <= rx_data_in;
                        3'h4: tgt_cdb_out[95:64] <= rx_data_in;
                        3'h5: tgt_cdb_out[127:96] <= rx_data_in;
                        default: begin
                        end
                    endcase
                end
            end
        end
    end
endmodule

/* sscsm_checker.sv */
// Purpose: Port assertions for the mapper.
// Assumes: One clock; ce_in held high.
// Notes: Bound into every mapper instance.
`timescale 1ns/1ns
`include "sscsm_defs.vh"
module sscsm_chk (
    input logic clk_sys_in,
    input logic reset_in,
    input logic conn_open_in,
    input logic [15:0] conn_it_in,
    input logic tx_valid_out,
    input logic [31:0] tx_data_out,
    input logic tx_sof_out,
    input logic tx_ready_in,
    input logic rx_valid_in,
    input logic rx_eof_in,
    input logic cmd_rcvd_out,
    input logic [15:0] tgt_it_out,
    input logic rsp_req_in,
    input logic rsp_busy_out,
    input logic din_valid_in,
    input logic din_ready_out,
    input logic irq_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    chk_tx_word_hold: assert property (tx_valid_out && !tx_ready_in |=>
        tx_valid_out && $stable(tx_data_out)) else $error("tx word moved before accept");
    chk_frame_type: assert property (tx_valid_out && tx_sof_out |-> tx_data_out[31:24] inside
        {`SSCSM_IU_DATA, `SSCSM_IU_COMMAND, `SSCSM_IU_RESPONSE}) else $error("bad frame type");
    chk_cmd_cause: assert property (cmd_rcvd_out |-> $past(rx_valid_in && rx_eof_in && conn_open_in))
        else $error("command pulse without frame end");
    chk_cmd_pulse: assert property (cmd_rcvd_out |=> !cmd_rcvd_out)
        else $error("command pulse too long");
    chk_tgt_pair: assert property (cmd_rcvd_out |-> tgt_it_out == conn_it_in)
        else $error("pair id not from connection");
    chk_rsp_busy: assert property (rsp_req_in && !rsp_busy_out |=> rsp_busy_out)
        else $error("response request not taken");
    chk_din_take: assert property (din_valid_in && din_ready_out |=> !din_ready_out)
        else $error("data ready not dropped");
    chk_reset_out: assert property (disable iff (1'b0) reset_in |=> !tx_valid_out && !irq_out && !cmd_rcvd_out)
        else $error("outputs active after reset");
endmodule
bind sscsm_mapper sscsm_chk i_sscsm_chk (.*);

/* sscsm_peer.sv */
// Purpose: Peer port that loops every accepted word back.
// Assumes: Same clock as the mapper.
// Notes: Idle receive data toggle so stale words never match.
`timescale 1ns/1ns
module sscsm_peer (
    input logic clk_sys_in,
    input logic v_in,
    input logic [31:0] d_in,
    input logic sof_in,
    input logic eof_in,
    output logic ready_out,
    output logic rv_out = 1'h0,
    output logic [31:0] rd_out = 32'h0,
    output logic rsof_out = 1'h0,
    output logic reof_out = 1'h0
);
    logic [1:0] cnt_r = 2'h0;
    logic a;
    // Stalling one cycle in four exercises held words.
    assign ready_out = cnt_r != 2'h3;
    assign a = v_in && ready_out;
    always @(posedge clk_sys_in) begin
        cnt_r <= cnt_r + 2'h1;
        rv_out <= a;
        rd_out <= a ? d_in : ~rd_out;
        rsof_out <= a && sof_in;
        reof_out <= a && eof_in;
    end
endmodule

/* sscsm_mapper_tb_top.sv */
// Purpose: Loopback bench for the mapper.
// Assumes: Peer returns each frame to the same port.
// Notes: Random fields from a fixed seed.
`timescale 1ns/1ns
module sscsm_mapper_tb_top;
    logic clk_sys_in = 0, reset_in = 1, ce_in = 1, wr_en_in = 0, rd_en_in = 0, conn_open_in = 1, rx_nak_in = 0;
    logic rsp_req_in = 0, rsp_info_valid_in = 0, din_valid_in = 0, din_last_in = 0;
    logic [7:0] addr_in = 0, rsp_lun_in = 0, rsp_status_in = 0, din_lun_in = 0, tgt_lun_out, lun, st;
    logic [15:0] conn_it_in = 16'h5A3C, rsp_tag_in = 0, din_tag_in = 0, tgt_it_out, tgt_tag_out, tag;
    logic [31:0] wr_data_in = 0, rsp_sense_in = 0, din_data_in = 0, rd_data_out, tx_data_out, rx_data_in;
    logic [31:0] tgt_din_bytes_out, seed = 32'h4D, w0, w1, cdb [4];
    logic irq_out, tx_valid_out, tx_sof_out, tx_eof_out, tx_ready_in, rx_valid_in, rx_sof_in, rx_eof_in;
    logic cmd_rcvd_out, rsp_busy_out, din_ready_out;
    logic [2:0] tgt_attr_out;
    logic [127:0] tgt_cdb_out;
    int errors = 0, n_checks = 0, k, i;
    sscsm_mapper i_sscsm_mapper (.*);
    sscsm_peer i_sscsm_peer (.clk_sys_in, .v_in(tx_valid_out), .d_in(tx_data_out), .sof_in(tx_sof_out),
        .eof_in(tx_eof_out), .ready_out(tx_ready_in), .rv_out(rx_valid_in), .rd_out(rx_data_in),
        .rsof_out(rx_sof_in), .reof_out(rx_eof_in));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [1:0] svc(logic iv, logic [7:0] s);
        return iv ? 2'h2 : (s == 8'h10 || s == 8'h14) ? 2'h1 : 2'h0;
    endfunction
    task chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_sys_in) {addr_in, wr_data_in, wr_en_in} <= {a, d, 1'h1};
        @(posedge clk_sys_in) wr_en_in <= 0;
    endtask
    task rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
        @(posedge clk_sys_in) {addr_in, rd_en_in} <= {a, 1'h1};
        @(posedge clk_sys_in) rd_en_in <= 0;
        #1 chk(rd_data_out & m, e);
    endtask
    task wt(bit s);
        for (i = 0; i < 300 && (s ? irq_out : cmd_rcvd_out) !== 1'h1; i++) @(negedge clk_sys_in);
        chk(i < 300, 1);
    endtask
    task din(logic [31:0] d, logic l);
        @(posedge clk_sys_in) {din_valid_in, din_data_in, din_last_in, din_lun_in, din_tag_in} <= {1'h1, d, l, lun, tag};
        do @(negedge clk_sys_in); while (din_ready_out !== 1'h1);
        @(posedge clk_sys_in) din_valid_in <= 0;
    endtask
    task give_verdict();
        if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial forever #10 clk_sys_in = ~clk_sys_in;
    initial begin
        #200000 errors++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk_sys_in);
        reset_in <= 0;
        rd(8'h1C, 0, '1);
        rd(8'h34, 0, '1);
        rd(8'h3C, 0, '1);
        w0 = rnd();
        wr(8'h20, w0);
        rd(8'h20, w0, '1);
        wr(8'h34, 1);
        for (k = 0; k < 5; k++) begin
            w0 = rnd();
            w1 = rnd();
            {lun, tag} = w0[23:0];
            st = (k == 0 || k == 3) ? 8'h10 : k == 1 ? 8'h14 : w1[7:0] & 8'hEF;
            wr(8'h04, {lun, tag});
            wr(8'h08, k);
            for (int j = 0; j < 4; j++) begin
                cdb[j] = rnd();
                wr(8'h0C + 8'(4 * j), cdb[j]);
            end
            wr(8'h1C, 32'h80);
            wr(8'h00, 1);
            rd(8'h00, 1, '1);
            wt(0);
            chk({tgt_lun_out, tgt_tag_out}, {lun, tag});
            chk(tgt_it_out, conn_it_in);
            chk(tgt_attr_out, k);
            for (int j = 0; j < 4; j++) chk(tgt_cdb_out[32*j+:32], cdb[j]);
            if (k == 4) begin
                @(posedge clk_sys_in) rx_nak_in <= 1;
                @(posedge clk_sys_in) rx_nak_in <= 0;
            end else begin
                w0 = rnd();
                w1 = rnd();
                din(w0, 0);
                din(w1, 1);
                repeat (6) @(posedge clk_sys_in);
                chk(tgt_din_bytes_out, 8);
                @(posedge clk_sys_in) {rsp_req_in, rsp_lun_in, rsp_tag_in, rsp_status_in} <= {1'h1, lun, tag, st};
                {rsp_info_valid_in, rsp_sense_in} <= {k == 3, w0 ^ w1};
                @(posedge clk_sys_in) rsp_req_in <= 0;
            end
            wt(1);
            rd(8'h00, 0, '1);
            if (k == 4) rd(8'h24, 32'h400, 32'h600);
            else begin
                rd(8'h24, {svc(k == 3, st), k == 3, st}, '1);
                rd(8'h28, w0 ^ w1, '1);
                rd(8'h2C, 8, '1);
                rd(8'h38, 1, '1);
                rd(8'h80, w0, '1);
                rd(8'h84, w1, '1);
            end
            rd(8'h30, k == 4 ? 5 : 7, '1);
            wr(8'h30, 32'hF);
            rd(8'h30, 0, '1);
            chk(irq_out, 0);
        end
        give_verdict();
    end
endmodule
